/* hw/pmevt_top.sv */
// Power-event logic: management interrupts, clock-stop, suspend, wake-up
//
// Behaviour
// R01: Output user pins drive software-written value
// R02: Input user pin activity raises interrupt request
// R03: Battery interrupts need both bits 5:4 set
// R04: Battery wake-up needs enable bits 1:0 set
// R05: Battery status readable at status bits 5:4
// R06: AC present clears battery bits, sets bit3
// R07: Very-low battery wakes system from suspend
// R08: Throttling toggles clock-stop, 1 ms each level
// R09: Software control bit 3 makes software interrupt
// R10: Option bit 7 auto-clears software interrupt
// R11: Software control bit 4 asserts clock-stop
// R12: Enabled wake-up source ends software clock-stop
// R13: Enabled switch press in operation enters suspend
// R14: Switch press in suspend returns to normal
// R15: Processor bus access wakes if bit 7
// R16: Selected interrupt lines wake if bit 6
// R17: DMA bit 5, bus master bit 4 wake
// R18: Trapped I/O address hit wakes if bit 3
// R19: Ring indicate activity wakes if bit 2
// R20: Alarm wakes if A8h bit 2 set
// R21: Interrupt sources ranked timeout down to software
// R22: Throttling is one first-level idle action
// R23: Disabled activity never wakes nor ends stop; very-low battery still leaves suspend with its enable bit clear
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module pmevt_top (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  input wire logic low_battery_input_in,
  input wire logic very_low_battery_input_in,
  input wire logic ac_power_in,
  input wire logic switch_press_in,
  input wire logic hw_timeout_in,
  input wire logic [3:0] gen_io_smi_in,
  input wire logic [2:0] user_io_pin_in,
  output logic [2:0] user_io_pin_out,
  output logic [2:0] user_io_pin_oe_out,
  input wire logic cpu_access_in,
  input wire logic [15:0] irq_lines_in,
  input wire logic dma_active_in,
  input wire logic bus_master_in,
  input wire logic io_access_in,
  input wire logic [15:0] io_addr_in,
  input wire logic ring_indicate_input_in,
  input wire logic rtc_alarm_in,
  output logic mgmt_interrupt_request_out,
  output logic cpu_clock_stop_request_out,
  output logic suspend_out,
  output logic [3:0] smi_source_out
);
  logic [15:0] irq_wake_sel;
  logic [7:0] rtc_wake;
  logic [7:0] pwr_ctrl;
  logic [7:0] wake_en;
  logic [15:0] trap_addr;
  logic [7:0] smi_opt;
  logic sw_smi;
  logic sw_stop;
  logic [2:0] uio_dir;
  logic [2:0] uio_val;
  logic throttle_req;
  pmevt_pkg::pmevt_mode_t mode;
  logic [pmevt_pkg::NUM_SRC-1:0] pending;
  logic [pmevt_pkg::NUM_SRC-1:0] raw_src;
  logic [2:0] uio_prev;
  logic [2:0] uio_rise;
  logic switch_prev;
  logic switch_edge;
  logic lb_stat;
  logic vlb_stat;
  logic ac_stat;
  logic batt_smi_en;
  logic wake_any;
  logic throttle_level;
  logic [3:0] top_src;
  logic wr_swctl;
  logic sel_read_src;
  pmevt_pkg::pmevt_act_t act;

  // Battery status, masked by AC presence
  assign ac_stat = ac_power_in; // see R06
  assign lb_stat = low_battery_input_in && !ac_power_in; // see R05
  assign vlb_stat = very_low_battery_input_in && !ac_power_in; // see R06
  assign batt_smi_en = pwr_ctrl[pmevt_pkg::PC_BATT_SMI_HI] &&
                       pwr_ctrl[pmevt_pkg::PC_BATT_SMI_LO]; // see R03
  assign switch_edge = switch_press_in && !switch_prev;
  assign wr_swctl = reg_write_in && (reg_addr_in == pmevt_pkg::SW_CTRL_ADDR);

  // Activity gathered per source
  assign act.cpu_access = cpu_access_in;
  assign act.irq_any = |(irq_lines_in & irq_wake_sel);
  assign act.dma = dma_active_in;
  assign act.bus_master = bus_master_in;
  assign act.io_trap = io_access_in && (io_addr_in == trap_addr);
  assign act.ring = ring_indicate_input_in;
  assign act.low_batt = lb_stat;
  assign act.very_low_batt = vlb_stat;
  assign act.rtc_alarm = rtc_alarm_in;

  // Wake-up qualification; each activity only counts with its enable.
  // A clear enable bit masks its source from wake_any, so a busy but
  // unselected bus cannot end a software clock-stop by accident.
  always_comb begin
    wake_any = 1'b0;
    if (act.cpu_access && wake_en[pmevt_pkg::WE_CPU]) begin
      wake_any = 1'b1; // see R15
    end
    if (act.irq_any && wake_en[pmevt_pkg::WE_IRQ]) begin
      wake_any = 1'b1; // see R16
    end
    if (act.dma && wake_en[pmevt_pkg::WE_DMA]) begin
      wake_any = 1'b1; // see R17
    end
    if (act.bus_master && wake_en[pmevt_pkg::WE_MASTER]) begin
      wake_any = 1'b1; // see R17
    end
    if (act.io_trap && wake_en[pmevt_pkg::WE_TRAP]) begin
      wake_any = 1'b1; // see R18
    end
    if (act.ring && wake_en[pmevt_pkg::WE_RING]) begin
      wake_any = 1'b1; // see R19
    end
    // Battery sources need both enable bits together
    if ((act.low_batt || act.very_low_batt) && wake_en[pmevt_pkg::WE_LB] &&
        wake_en[pmevt_pkg::WE_VLB]) begin
      wake_any = 1'b1; // see R04
    end
    // The alarm is enabled from its own register, not the wake byte
    if (act.rtc_alarm && rtc_wake[pmevt_pkg::RTC_WAKE_BIT]) begin
      wake_any = 1'b1; // see R20
    end
  end

  // Raw interrupt events, ranked by index (10 highest)
  always_comb begin
    raw_src = '0;
    raw_src[10] = hw_timeout_in; // see R21
    raw_src[9] = vlb_stat && batt_smi_en; // see R03
    raw_src[8] = lb_stat && batt_smi_en; // see R03
    raw_src[7:4] = gen_io_smi_in;
    raw_src[0] = sw_smi; // see R09
  end

  // Per user pin: rising edge on an input-configured pin is an event.
  // An output pin never raises a request, even when it reads back high.
  genvar gi;
  generate
    for (gi = 0; gi < pmevt_pkg::NUM_UIO; gi++) begin : g_uio
      assign uio_rise[gi] = user_io_pin_in[gi] && !uio_prev[gi] &&
                            !uio_dir[gi]; // see R02
      assign user_io_pin_oe_out[gi] = uio_dir[gi]; // see R01
    end
  endgenerate

  // Pending sources are sticky; a new event wins over a read clear
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pending <= '0;
    end else begin
      pending <= (sel_read_src ? '0 : pending) | raw_src |
                 {7'h00, uio_rise, 1'b0}; // see R02
    end
  end
  assign sel_read_src = reg_read_in &&
                        (reg_addr_in == pmevt_pkg::SMI_SRC_ADDR);

  // Highest-ranked pending source number
  always_comb begin
    top_src = 4'hF;
    for (int i = 0; i < pmevt_pkg::NUM_SRC; i++) begin
      if (pending[i]) top_src = 4'(i); // see R21
    end
  end

  // Edge history
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      uio_prev <= 3'h0;
      switch_prev <= 1'b0;
    end else begin
      uio_prev <= user_io_pin_in;
      switch_prev <= switch_press_in;
    end
  end

  // Configuration registers written by software
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      irq_wake_sel <= pmevt_pkg::RESET_WORD;
      rtc_wake <= pmevt_pkg::RESET_BYTE;
      pwr_ctrl <= pmevt_pkg::RESET_BYTE;
      wake_en <= pmevt_pkg::RESET_BYTE;
      trap_addr <= pmevt_pkg::RESET_WORD;
      smi_opt <= pmevt_pkg::RESET_BYTE;
      uio_dir <= 3'h0;
      uio_val <= 3'h0;
      throttle_req <= 1'b0;
    end else if (reg_write_in) begin
      case (reg_addr_in)
        pmevt_pkg::IRQ_WAKE_LO_ADDR: irq_wake_sel[7:0] <= reg_wdata_in;
        pmevt_pkg::IRQ_WAKE_HI_ADDR: irq_wake_sel[15:8] <= reg_wdata_in;
        pmevt_pkg::RTC_WAKE_ADDR: rtc_wake <= reg_wdata_in;
        pmevt_pkg::PWR_CTRL_ADDR: pwr_ctrl <= reg_wdata_in;
        pmevt_pkg::WAKE_EN_ADDR: wake_en <= reg_wdata_in;
        pmevt_pkg::TRAP_ADDR_LO_ADDR: trap_addr[7:0] <= reg_wdata_in;
        pmevt_pkg::TRAP_ADDR_HI_ADDR: trap_addr[15:8] <= reg_wdata_in;
        pmevt_pkg::SMI_OPT_ADDR: smi_opt <= reg_wdata_in;
        pmevt_pkg::UIO_DIR_ADDR: uio_dir <= reg_wdata_in[2:0];
        pmevt_pkg::UIO_OUT_ADDR: uio_val <= reg_wdata_in[2:0];
        pmevt_pkg::MODE_CTRL_ADDR:
          throttle_req <= reg_wdata_in[pmevt_pkg::MC_THROTTLE];
        default: ;
      endcase
    end
  end

  // Software interrupt bit; auto-clear once the request has been issued
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sw_smi <= 1'b0;
    end else if (wr_swctl && reg_wdata_in[pmevt_pkg::SC_SW_SMI]) begin
      sw_smi <= 1'b1; // see R09
    end else if (wr_swctl) begin
      sw_smi <= 1'b0;
    end else if (smi_opt[pmevt_pkg::SO_AUTO_CLR] && pending[0]) begin
      sw_smi <= 1'b0; // see R10
    end
  end

  // Software clock-stop bit, ended by any enabled wake-up activity;
  // a write during wake activity is dropped, the wake would end it anyway
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sw_stop <= 1'b0;
    end else if (wake_any) begin
      sw_stop <= 1'b0; // see R12, see R23
    end else if (wr_swctl) begin
      sw_stop <= reg_wdata_in[pmevt_pkg::SC_SW_STOP]; // see R11
    end
  end

  // Operating mode: normal, throttle (first idle level), suspend
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      mode <= pmevt_pkg::PMEVT_NORMAL;
    end else begin
      case (mode)
        pmevt_pkg::PMEVT_NORMAL: begin
          if (switch_edge && pwr_ctrl[pmevt_pkg::PC_SWITCH_EN])
            mode <= pmevt_pkg::PMEVT_SUSPEND; // see R13
          else if (throttle_req)
            mode <= pmevt_pkg::PMEVT_THROTTLE; // see R22
        end
        pmevt_pkg::PMEVT_THROTTLE: begin
          if (switch_edge && pwr_ctrl[pmevt_pkg::PC_SWITCH_EN])
            mode <= pmevt_pkg::PMEVT_SUSPEND; // see R13
          else if (!throttle_req || wake_any)
            mode <= pmevt_pkg::PMEVT_NORMAL; // see R23
        end
        pmevt_pkg::PMEVT_SUSPEND: begin
          if (switch_edge)
            mode <= pmevt_pkg::PMEVT_NORMAL; // see R14
          else if (vlb_stat || wake_any)
            mode <= pmevt_pkg::PMEVT_NORMAL; // see R07
        end
        default: mode <= pmevt_pkg::PMEVT_NORMAL;
      endcase
    end
  end

  // Periodic clock-stop generator used in throttle mode
  pmevt_throttle u_throttle (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .enable_in(mode == pmevt_pkg::PMEVT_THROTTLE),
    .level_out(throttle_level)
  );

  // Registered outputs to the processor and pins
  // Software clock-stop drops in the cycle the wake is seen, not one cycle later
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      mgmt_interrupt_request_out <= 1'b0;
      cpu_clock_stop_request_out <= 1'b0;
      suspend_out <= 1'b0;
      smi_source_out <= 4'hF;
      user_io_pin_out <= 3'h0;
    end else begin
      mgmt_interrupt_request_out <= |pending; // see R02
      cpu_clock_stop_request_out <= (sw_stop && !wake_any) ||
                                    throttle_level; // see R08, see R11
      suspend_out <= (mode == pmevt_pkg::PMEVT_SUSPEND);
      smi_source_out <= top_src;
      user_io_pin_out <= uio_val & uio_dir; // see R01
    end
  end

  // Read data, one cycle after the read strobe; zero otherwise
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        pmevt_pkg::IRQ_WAKE_LO_ADDR: reg_rdata_out <= irq_wake_sel[7:0];
        pmevt_pkg::IRQ_WAKE_HI_ADDR: reg_rdata_out <= irq_wake_sel[15:8];
        pmevt_pkg::RTC_WAKE_ADDR: reg_rdata_out <= rtc_wake;
        pmevt_pkg::PWR_CTRL_ADDR: reg_rdata_out <= pwr_ctrl;
        pmevt_pkg::WAKE_EN_ADDR: reg_rdata_out <= wake_en;
        pmevt_pkg::TRAP_ADDR_LO_ADDR: reg_rdata_out <= trap_addr[7:0];
        pmevt_pkg::TRAP_ADDR_HI_ADDR: reg_rdata_out <= trap_addr[15:8];
        // Status bits are live levels; AC presence already masks battery
        pmevt_pkg::PWR_STATUS_ADDR:
          reg_rdata_out <= {2'b00, vlb_stat, lb_stat, ac_stat,
                            3'b000}; // see R05
        pmevt_pkg::SMI_OPT_ADDR: reg_rdata_out <= smi_opt;
        pmevt_pkg::SW_CTRL_ADDR:
          reg_rdata_out <= {3'b000, sw_stop, sw_smi, 3'b000};
        pmevt_pkg::UIO_DIR_ADDR: reg_rdata_out <= {5'h00, uio_dir};
        pmevt_pkg::UIO_OUT_ADDR: reg_rdata_out <= {5'h00, user_io_pin_in};
        pmevt_pkg::SMI_SRC_ADDR: reg_rdata_out <= pending[7:0];
        pmevt_pkg::SMI_SRC_HI_ADDR: reg_rdata_out <= {5'h00, pending[10:8]};
        pmevt_pkg::MODE_CTRL_ADDR:
          reg_rdata_out <= {6'h00, mode == pmevt_pkg::PMEVT_SUSPEND,
                            throttle_req};
        default: reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end
endmodule : pmevt_top
`default_nettype wire

/* hw/pmevt_pkg.sv */
// Package: register offsets, field positions, reset values and timing
package pmevt_pkg;
  // Register offsets on the plain register port (8-bit address)
  localparam logic [7:0] IRQ_WAKE_LO_ADDR = 8'h88;
  localparam logic [7:0] IRQ_WAKE_HI_ADDR = 8'h89;
  localparam logic [7:0] RTC_WAKE_ADDR = 8'hA8;
  localparam logic [7:0] PWR_CTRL_ADDR = 8'hAA;
  localparam logic [7:0] WAKE_EN_ADDR = 8'hAB;
  localparam logic [7:0] TRAP_ADDR_LO_ADDR = 8'hAC;
  localparam logic [7:0] TRAP_ADDR_HI_ADDR = 8'hAD;
  localparam logic [7:0] PWR_STATUS_ADDR = 8'hAF;
  localparam logic [7:0] SMI_OPT_ADDR = 8'hB4;
  localparam logic [7:0] SW_CTRL_ADDR = 8'hB6;
  localparam logic [7:0] UIO_DIR_ADDR = 8'hB8;
  localparam logic [7:0] UIO_OUT_ADDR = 8'hB9;
  localparam logic [7:0] SMI_SRC_ADDR = 8'hBA;
  localparam logic [7:0] SMI_SRC_HI_ADDR = 8'hBB;
  localparam logic [7:0] MODE_CTRL_ADDR = 8'hBC;
  // Field positions
  localparam int PC_BATT_SMI_LO = 4;
  localparam int PC_BATT_SMI_HI = 5;
  localparam int PC_SWITCH_EN = 6;
  localparam int WE_LB = 0;
  localparam int WE_VLB = 1;
  localparam int WE_RING = 2;
  localparam int WE_TRAP = 3;
  localparam int WE_MASTER = 4;
  localparam int WE_DMA = 5;
  localparam int WE_IRQ = 6;
  localparam int WE_CPU = 7;
  localparam int RTC_WAKE_BIT = 2;
  localparam int ST_AC = 3;
  localparam int ST_LB = 4;
  localparam int ST_VLB = 5;
  localparam int SO_AUTO_CLR = 7;
  localparam int SC_SW_SMI = 3;
  localparam int SC_SW_STOP = 4;
  localparam int MC_THROTTLE = 0;
  localparam int MC_SUSPEND = 1;
  localparam int NUM_UIO = 3;
  localparam int NUM_GIO = 4;
  // Pending source vector: index = rank, 10 highest, 0 lowest (software)
  localparam int NUM_SRC = 11;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // Throttle half period
  localparam int THROTTLE_HALF_US = 1000;
  localparam int CLOCK_MHZ = 100;
  localparam int THROTTLE_HALF_CYC = THROTTLE_HALF_US * CLOCK_MHZ;
  typedef enum logic [1:0] {
    PMEVT_NORMAL = 2'b00,
    PMEVT_THROTTLE = 2'b01,
    PMEVT_SUSPEND = 2'b10
  } pmevt_mode_t;
  // Activity inputs that may wake the system
  typedef struct packed {
    logic cpu_access;
    logic irq_any;
    logic dma;
    logic bus_master;
    logic io_trap;
    logic ring;
    logic low_batt;
    logic very_low_batt;
    logic rtc_alarm;
  } pmevt_act_t;
endpackage : pmevt_pkg

/* hw/pmevt_throttle.sv */
// Throttle timer: 1 ms high, 1 ms low square wave while enabled
`timescale 1ns/10ps
`default_nettype none
module pmevt_throttle #(
  parameter int HALF_CYC = pmevt_pkg::THROTTLE_HALF_CYC
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic enable_in,
  output logic level_out
);
  logic [16:0] count;
  // Count one half period, then flip the level; restart high when enabled
  always_ff @(posedge clock_in) begin
    if (reset_in || !enable_in) begin
      count <= 17'h0_0000;
      level_out <= 1'b0;
    end else if (count == 17'h0_0000) begin
      count <= 17'(HALF_CYC - 1);
      level_out <= ~level_out; // see R08
    end else begin
      count <= count - 17'h0_0001;
    end
  end
endmodule : pmevt_throttle
`default_nettype wire

/* bench/pmevt_top_sva.sv */
// Checker: port-level properties of the power-event block
`timescale 1ns/10ps
`default_nettype none
module pmevt_top_sva (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic very_low_battery_input_in,
  input wire logic ac_power_in,
  input wire logic switch_press_in,
  input wire logic hw_timeout_in,
  input wire logic [2:0] user_io_pin_oe_out,
  input wire logic mgmt_interrupt_request_out,
  input wire logic suspend_out,
  input wire logic [3:0] smi_source_out
);
  logic sw_en;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);
  // Shadow of the switch enable bit, kept from register writes
  always_ff @(posedge clock_in) begin
    if (reset_in)
      sw_en <= 1'h0;
    else if (reg_write_in && reg_addr_in == pmevt_pkg::PWR_CTRL_ADDR)
      sw_en <= reg_wdata_in[pmevt_pkg::PC_SWITCH_EN];
  end
  // Read data is zero outside the cycle after a read strobe
  a_read_data_idle: assert property (
    !$past(reg_read_in) |-> reg_rdata_out == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_pin_dir_write: assert property (
    $past(reg_write_in) && $past(reg_addr_in) == pmevt_pkg::UIO_DIR_ADDR
    |-> user_io_pin_oe_out == $past(reg_wdata_in[2:0]))
    else $error("pin enables differ from written direction");
  a_smi_flag_rank: assert property (
    mgmt_interrupt_request_out == (smi_source_out != 4'hF))
    else $error("interrupt request and source rank disagree");
  a_sw_smi_raise: assert property (
    reg_write_in && reg_addr_in == pmevt_pkg::SW_CTRL_ADDR
    && reg_wdata_in[pmevt_pkg::SC_SW_SMI]
    |-> ##[1:3] mgmt_interrupt_request_out)
    else $error("software interrupt not raised");
  a_timeout_top: assert property (
    hw_timeout_in |-> ##[1:3] smi_source_out == 4'hA)
    else $error("timeout source not ranked highest");
  a_switch_enter: assert property (
    $rose(switch_press_in) && sw_en && !suspend_out |-> ##[1:3] suspend_out)
    else $error("enabled switch press did not suspend");
  a_switch_leave: assert property (
    $rose(switch_press_in) && suspend_out |-> ##[1:3] !suspend_out)
    else $error("switch press did not leave suspend");
  a_vlb_wake: assert property (
    very_low_battery_input_in && !ac_power_in && suspend_out
    |-> ##[1:3] !suspend_out)
    else $error("very low battery did not wake system");
endmodule : pmevt_top_sva
bind pmevt_top pmevt_top_sva i_sva (.clock_in(clock_in),
  .reset_in(reset_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .very_low_battery_input_in(very_low_battery_input_in),
  .ac_power_in(ac_power_in),
  .switch_press_in(switch_press_in), .hw_timeout_in(hw_timeout_in),
  .user_io_pin_oe_out(user_io_pin_oe_out),
  .mgmt_interrupt_request_out(mgmt_interrupt_request_out),
  .suspend_out(suspend_out), .smi_source_out(smi_source_out));
`default_nettype wire

/* bench/pmevt_host_model.sv */
// Host model: counts management interrupts and follows clock-stop
`timescale 1ns/10ps
`default_nettype none
module pmevt_host_model (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic smi_in,
  input wire logic stop_in,
  output logic [7:0] smi_count_out,
  output logic stopped_out
);
  logic smi_q;
  // Count each new interrupt request and mirror the stop state
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      smi_q <= 1'h0;
      smi_count_out <= 8'h00;
      stopped_out <= 1'h0;
    end else begin
      smi_q <= smi_in;
      stopped_out <= stop_in;
      if (smi_in && !smi_q)
        smi_count_out <= smi_count_out + 8'h01;
    end
  end
endmodule : pmevt_host_model
`default_nettype wire

/* bench/tb_top.sv */
// Testbench: register-driven scenarios for the power-event block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clock_in = 1'h0;
  logic reset_in = 1'h1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rd_val, smi_count;
  logic wr = 1'h0, rd = 1'h0, lb = 1'h0, vlb = 1'h0, ac = 1'h0, sw = 1'h0;
  logic tmo = 1'h0, cpu = 1'h0, dma = 1'h0, bm = 1'h0, ioa = 1'h0;
  logic ring = 1'h0, rtc = 1'h0, smi, stop, susp, stopped;
  logic [3:0] gio = 4'h0, src;
  logic [2:0] pin_in = 3'h0, pin_out, pin_oe;
  logic [15:0] irq = 16'h0000, io_addr = 16'h0300;
  logic [7:0] en_tab [8] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04,
    8'h03, 8'h04};
  int fails = 0, tests_run = 0, hi = 0;
  // Free-running 100 MHz clock
  always #5 clock_in = ~clock_in;
  pmevt_top i_dut (.clock_in(clock_in), .reset_in(reset_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr),
    .reg_read_in(rd), .reg_rdata_out(rdata), .low_battery_input_in(lb),
    .very_low_battery_input_in(vlb), .ac_power_in(ac),
    .switch_press_in(sw), .hw_timeout_in(tmo), .gen_io_smi_in(gio),
    .user_io_pin_in(pin_in), .user_io_pin_out(pin_out),
    .user_io_pin_oe_out(pin_oe), .cpu_access_in(cpu), .irq_lines_in(irq),
    .dma_active_in(dma), .bus_master_in(bm), .io_access_in(ioa),
    .io_addr_in(io_addr), .ring_indicate_input_in(ring),
    .rtc_alarm_in(rtc), .mgmt_interrupt_request_out(smi),
    .cpu_clock_stop_request_out(stop), .suspend_out(susp),
    .smi_source_out(src));
  pmevt_host_model i_host (.clock_in(clock_in), .reset_in(reset_in),
    .smi_in(smi), .stop_in(stop), .smi_count_out(smi_count),
    .stopped_out(stopped));
  // Compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clock_in);
    wr <= 1'h0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clock_in);
    rd <= 1'h1;
    addr <= a;
    @(posedge clock_in);
    rd <= 1'h0;
    #1 rd_val = rdata;
  endtask : rd_reg
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : wait_cyc
  // Drive one activity input chosen by table index
  task automatic act(input int i, input logic v);
    @(posedge clock_in);
    case (i)
      0: cpu <= v;
      1: irq <= {15'h0000, v};
      2: dma <= v;
      3: bm <= v;
      4: ioa <= v;
      5: ring <= v;
      6: lb <= v;
      default: rtc <= v;
    endcase
  endtask : act
  task automatic pulse(input int i);
    act(i, 1'h1);
    act(i, 1'h0);
    wait_cyc(3);
  endtask : pulse
  task automatic press();
    @(posedge clock_in);
    sw <= 1'h1;
    @(posedge clock_in);
    sw <= 1'h0;
    wait_cyc(3);
  endtask : press
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // Hang guard
  initial begin
    #500000;
    fails++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clock_in);
    reset_in <= 1'h0;
    rd_reg(pmevt_pkg::WAKE_EN_ADDR);
    check(rd_val, 8'h00);
    rd_reg(8'h50);
    check(rd_val, 8'h00);
    $display("test registers done");
    wr_reg(pmevt_pkg::UIO_DIR_ADDR, 8'h07);
    wr_reg(pmevt_pkg::UIO_OUT_ADDR, 8'h05);
    wait_cyc(1);
    check({5'h00, pin_out}, 8'h05);
    check({5'h00, pin_oe}, 8'h07);
    wr_reg(pmevt_pkg::UIO_DIR_ADDR, 8'h00);
    pin_in <= 3'h1;
    wait_cyc(3);
    check({4'h0, src}, 8'h01);
    rd_reg(pmevt_pkg::SMI_SRC_ADDR);
    wr_reg(pmevt_pkg::SW_CTRL_ADDR, 8'h08);
    wait_cyc(3);
    check({4'h0, src}, 8'h00);
    wr_reg(pmevt_pkg::SMI_OPT_ADDR, 8'h80);
    rd_reg(pmevt_pkg::SMI_SRC_ADDR);
    wr_reg(pmevt_pkg::SW_CTRL_ADDR, 8'h08);
    wait_cyc(4);
    check(smi_count, 8'h03);
    rd_reg(pmevt_pkg::SW_CTRL_ADDR);
    check(rd_val, 8'h00);
    rd_reg(pmevt_pkg::SMI_SRC_ADDR);
    wait_cyc(3);
    check({7'h00, smi}, 8'h00);
    wr_reg(pmevt_pkg::SMI_OPT_ADDR, 8'h00);
    $display("test pins and software done");
    wr_reg(pmevt_pkg::PWR_CTRL_ADDR, 8'h10);
    gio <= 4'h9;
    lb <= 1'h1;
    wait_cyc(3);
    check({4'h0, src}, 8'h07);
    wr_reg(pmevt_pkg::PWR_CTRL_ADDR, 8'h30);
    wait_cyc(3);
    check({4'h0, src}, 8'h08);
    @(posedge clock_in);
    vlb <= 1'h1;
    tmo <= 1'h1;
    wait_cyc(3);
    check({4'h0, src}, 8'h0A);
    rd_reg(pmevt_pkg::PWR_STATUS_ADDR);
    check(rd_val & 8'h38, 8'h30);
    @(posedge clock_in);
    ac <= 1'h1;
    wait_cyc(3);
    rd_reg(pmevt_pkg::PWR_STATUS_ADDR);
    check(rd_val & 8'h38, 8'h08);
    @(posedge clock_in);
    {ac, lb, vlb, tmo, gio} <= 8'h00;
    wr_reg(pmevt_pkg::PWR_CTRL_ADDR, 8'h00);
    rd_reg(pmevt_pkg::SMI_SRC_ADDR);
    wait_cyc(3);
    check({7'h00, smi}, 8'h00);
    $display("test battery done");
    press();
    check({7'h00, susp}, 8'h00);
    wr_reg(pmevt_pkg::PWR_CTRL_ADDR, 8'h40);
    press();
    check({7'h00, susp}, 8'h01);
    press();
    check({7'h00, susp}, 8'h00);
    press();
    @(posedge clock_in);
    vlb <= 1'h1;
    wait_cyc(3);
    check({7'h00, susp}, 8'h00);
    @(posedge clock_in);
    vlb <= 1'h0;
    $display("test suspend done");
    wr_reg(pmevt_pkg::IRQ_WAKE_LO_ADDR, 8'hFF);
    wr_reg(pmevt_pkg::TRAP_ADDR_HI_ADDR, 8'h03);
    for (int i = 0; i < 8; i++) begin
      wr_reg(pmevt_pkg::WAKE_EN_ADDR, 8'h00);
      wr_reg(pmevt_pkg::RTC_WAKE_ADDR, 8'h00);
      wr_reg(pmevt_pkg::SW_CTRL_ADDR, 8'h10);
      wait_cyc(3);
      check({7'h00, stop}, 8'h01);
      pulse(i);
      check({7'h00, stop}, 8'h01);
      wr_reg(i == 7 ? pmevt_pkg::RTC_WAKE_ADDR : pmevt_pkg::WAKE_EN_ADDR,
        en_tab[i]);
      pulse(i);
      check({7'h00, stop}, 8'h00);
    end
    $display("test wake sources done");
    wr_reg(pmevt_pkg::MODE_CTRL_ADDR, 8'h01);
    wait_cyc(3);
    for (int c = 0; c < 1000; c++) begin
      wait_cyc(1);
      hi += int'(stopped === 1'h1);
    end
    check(hi[7:0], 8'hE8);
    wr_reg(pmevt_pkg::MODE_CTRL_ADDR, 8'h00);
    wait_cyc(3);
    check({7'h00, stop}, 8'h00);
    $display("test throttle done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
